/* logic/dual_probe_position_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_probe_position_latch
  import probe_latch_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int TURN_W = 20
)
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // digital input terminals
  input wire logic digital_input_terminal_a,
  input wire logic digital_input_terminal_b,
  // encoder feedback
  input wire logic enc_ref_pulse,
  input wire logic enc_absolute,
  input wire logic [TURN_W-1:0] enc_turn_pos,
  input wire logic signed [POS_W-1:0] cmd_position
);
  logic [15:0] control_r, control_nxt;
  logic [7:0] input_function_assign_a_r, input_function_assign_a_nxt;
  logic [7:0] input_function_assign_b_r, input_function_assign_b_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [TURN_W-1:0] turn_last_r, turn_last_nxt;
  logic abs_ref_r, abs_ref_nxt;
  logic [TURN_W-1:0] turn_meta_r, turn_sync_r, turn_meta_nxt, turn_sync_nxt;
  logic abs_meta_r, abs_sync_r, abs_meta_nxt, abs_sync_nxt;
  chan_cfg_type cfg1, cfg2;
  edge_type din_a_edge, din_b_edge, zpulse_edge, ref_edge, din1_edge, din2_edge;
  logic r1_done, f1_done, r2_done, f2_done;
  logic signed [31:0] r1_pos, f1_pos, r2_pos, f2_pos;
  logic [15:0] state_word;
  logic setup, access, wr_ok, hit, any_strb;

  // maps one terminal's edges onto a channel given its function code
  function automatic edge_type route_din(input logic [7:0] code, input logic [7:0] high,
    input logic [7:0] low, input edge_type e);
    route_din = '0;
    if (code == high)
      route_din = e;
    else if (code == low)
    begin
      route_din.rise = e.fall;
      route_din.fall = e.rise;
    end
  endfunction

  probe_sync_edge u_sync_a (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(digital_input_terminal_a),
    .edges(din_a_edge)
  );

  probe_sync_edge u_sync_b (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(digital_input_terminal_b),
    .edges(din_b_edge)
  );

  probe_sync_edge u_sync_z (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(enc_ref_pulse),
    .edges(zpulse_edge)
  );

  always_comb
  begin
    cfg1 = cfg_of(control_r, 0);
    cfg2 = cfg_of(control_r, CH2_OFS);
    din1_edge = route_din(input_function_assign_a_r, FUNC_CH1_HIGH, FUNC_CH1_LOW, din_a_edge)
      | route_din(input_function_assign_b_r, FUNC_CH1_HIGH, FUNC_CH1_LOW, din_b_edge);
    din2_edge = route_din(input_function_assign_a_r, FUNC_CH2_HIGH, FUNC_CH2_LOW, din_a_edge)
      | route_din(input_function_assign_b_r, FUNC_CH2_HIGH, FUNC_CH2_LOW, din_b_edge);
    // absolute encoder: a one-cycle pulse when single-turn position wraps through zero
    abs_ref_nxt = abs_sync_r && (turn_sync_r == '0) && (turn_last_r != '0);
    turn_last_nxt = turn_sync_r;
    turn_meta_nxt = enc_turn_pos;
    turn_sync_nxt = turn_meta_r;
    abs_meta_nxt = enc_absolute;
    abs_sync_nxt = abs_meta_r;
    if (abs_sync_r)
    begin
      ref_edge.rise = abs_ref_nxt;
      ref_edge.fall = abs_ref_r;
    end
    else
      ref_edge = zpulse_edge;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      turn_meta_r <= '0;
      turn_sync_r <= '0;
      abs_meta_r <= 1'b0;
      abs_sync_r <= 1'b0;
      turn_last_r <= '0;
      abs_ref_r <= 1'b0;
    end
    else
    begin
      turn_meta_r <= turn_meta_nxt;
      turn_sync_r <= turn_sync_nxt;
      abs_meta_r <= abs_meta_nxt;
      abs_sync_r <= abs_sync_nxt;
      turn_last_r <= turn_last_nxt;
      abs_ref_r <= abs_ref_nxt;
    end
  end

  probe_channel u_ch1 (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg1),
    .din_edge(din1_edge),
    .ref_edge(ref_edge),
    .position(32'(cmd_position)),
    .rise_done(r1_done),
    .fall_done(f1_done),
    .rise_pos(r1_pos),
    .fall_pos(f1_pos)
  );

  probe_channel u_ch2 (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg2),
    .din_edge(din2_edge),
    .ref_edge(ref_edge),
    .position(32'(cmd_position)),
    .rise_done(r2_done),
    .fall_done(f2_done),
    .rise_pos(r2_pos),
    .fall_pos(f2_pos)
  );

  // apb: one wait state, answer registered in the access cycle
  always_comb
  begin
    state_word = '0;
    state_word[ST_EN] = cfg1.en;
    state_word[ST_RISE] = r1_done;
    state_word[ST_FALL] = f1_done;
    state_word[CH2_OFS + ST_EN] = cfg2.en;
    state_word[CH2_OFS + ST_RISE] = r2_done;
    state_word[CH2_OFS + ST_FALL] = f2_done;
    setup = psel & ~penable;
    access = psel & penable & ~pready_r;
    any_strb = |pstrb;
    control_nxt = control_r;
    input_function_assign_a_nxt = input_function_assign_a_r;
    input_function_assign_b_nxt = input_function_assign_b_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = access;
    hit = 1'b1;
    wr_ok = access & pwrite;
    if (access)
    begin
      prdata_nxt = '0;
      unique case (paddr)
        byte_addr(IDX_CONTROL):
        begin
          prdata_nxt[15:0] = control_r;
          if (wr_ok && any_strb)
          begin
            if (pstrb[0])
              control_nxt[7:0] = pwdata[7:0] & CONTROL_MASK[7:0];
            if (pstrb[1])
              control_nxt[15:8] = pwdata[15:8] & CONTROL_MASK[15:8];
          end
        end
        byte_addr(IDX_STATE):
          prdata_nxt[15:0] = state_word;
        byte_addr(IDX_C1_RISE):
          prdata_nxt = r1_pos;
        byte_addr(IDX_C1_FALL):
          prdata_nxt = f1_pos;
        byte_addr(IDX_C2_RISE):
          prdata_nxt = r2_pos;
        byte_addr(IDX_C2_FALL):
          prdata_nxt = f2_pos;
        byte_addr(IDX_ASSIGN_A):
        begin
          prdata_nxt[7:0] = input_function_assign_a_r;
          if (wr_ok && pstrb[0])
            input_function_assign_a_nxt = pwdata[7:0];
        end
        byte_addr(IDX_ASSIGN_B):
        begin
          prdata_nxt[7:0] = input_function_assign_b_r;
          if (wr_ok && pstrb[0])
            input_function_assign_b_nxt = pwdata[7:0];
        end
        default:
          hit = 1'b0;
      endcase
      pslverr_nxt = ~hit;
      if (pwrite)
        prdata_nxt = '0;
    end
    else if (setup)
      prdata_nxt = '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_r <= CONTROL_RST;
      input_function_assign_a_r <= FUNC_RST;
      input_function_assign_b_r <= FUNC_RST;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      control_r <= control_nxt;
      input_function_assign_a_r <= input_function_assign_a_nxt;
      input_function_assign_b_r <= input_function_assign_b_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  property p_state_mirror;
    @(posedge pclk) disable iff (!presetn)
    (state_word[ST_EN] == control_r[BIT_EN])
      && (state_word[CH2_OFS + ST_EN] == control_r[CH2_OFS + BIT_EN]);
  endproperty
  a_state_mirror: assert property (p_state_mirror)
    else $error("status enable does not mirror control");

  property p_state_unused_zero;
    @(posedge pclk) disable iff (!presetn)
    (state_word & 16'hf8f8) == 16'h0000;
  endproperty
  a_state_unused_zero: assert property (p_state_unused_zero)
    else $error("unused status bit set");

  property p_ctl_unused_zero;
    @(posedge pclk) disable iff (!presetn)
    (control_r & ~CONTROL_MASK) == 16'h0000;
  endproperty
  a_ctl_unused_zero: assert property (p_ctl_unused_zero)
    else $error("reserved control bit stored");

  property p_ctl_write;
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == byte_addr(IDX_CONTROL) && pstrb[1:0] == 2'b11)
      |=> control_r == ($past(pwdata[15:0]) & CONTROL_MASK);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write not stored");

  property p_ch2_layout;
    @(posedge pclk) disable iff (!presetn)
    cfg2.rise_en == control_r[12] && cfg2.fall_en == control_r[13]
      && cfg2.src_ref == control_r[10] && cfg2.continuous == control_r[9];
  endproperty
  a_ch2_layout: assert property (p_ch2_layout)
    else $error("channel two field decode wrong");

  property p_apb_one_wait;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) ##1 (psel && penable) |=> pready ##1 !pready;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait)
    else $error("apb answer not after one wait");

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held longer than one cycle");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
    (access && !hit) |=> pready && pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access without error");

  property p_ro_no_error;
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == byte_addr(IDX_C1_RISE)) |=> pready && !pslverr;
  endproperty
  a_ro_no_error: assert property (p_ro_no_error)
    else $error("write to read-only capture flagged as error");

  property p_capture_read;
    @(posedge pclk) disable iff (!presetn)
    (access && !pwrite && paddr == byte_addr(IDX_C1_RISE)) |=> prdata == $past(r1_pos);
  endproperty
  a_capture_read: assert property (p_capture_read)
    else $error("capture read returned wrong word");

  property p_state_read;
    @(posedge pclk) disable iff (!presetn)
    (access && !pwrite && paddr == byte_addr(IDX_STATE))
      |=> prdata == {16'h0000, $past(state_word)};
  endproperty
  a_state_read: assert property (p_state_read)
    else $error("status read returned wrong word");

  property p_din_route_high;
    @(posedge pclk) disable iff (!presetn)
    (input_function_assign_a_r == FUNC_CH1_HIGH && input_function_assign_b_r != FUNC_CH1_HIGH
      && input_function_assign_b_r != FUNC_CH1_LOW) |-> din1_edge == din_a_edge;
  endproperty
  a_din_route_high: assert property (p_din_route_high)
    else $error("active-high terminal not routed to channel one");

  property p_din_route_low;
    @(posedge pclk) disable iff (!presetn)
    (input_function_assign_b_r == FUNC_CH2_LOW && input_function_assign_a_r != FUNC_CH2_HIGH
      && input_function_assign_a_r != FUNC_CH2_LOW)
      |-> din2_edge.rise == din_b_edge.fall && din2_edge.fall == din_b_edge.rise;
  endproperty
  a_din_route_low: assert property (p_din_route_low)
    else $error("active-low terminal not inverted for channel two");

  property p_abs_ref_once;
    @(posedge pclk) disable iff (!presetn)
    (abs_sync_r && ref_edge.rise) |=> !ref_edge.rise && ref_edge.fall;
  endproperty
  a_abs_ref_once: assert property (p_abs_ref_once)
    else $error("absolute reference pulse not one cycle wide");
endmodule
`default_nettype wire

/* logic/probe_latch_pkg.sv */
package probe_latch_pkg;
  localparam logic [15:0] IDX_CONTROL = 16'h60b8;
  localparam logic [15:0] IDX_STATE = 16'h60b9;
  localparam logic [15:0] IDX_C1_RISE = 16'h60ba;
  localparam logic [15:0] IDX_C1_FALL = 16'h60bb;
  localparam logic [15:0] IDX_C2_RISE = 16'h60bc;
  localparam logic [15:0] IDX_C2_FALL = 16'h60bd;
  // own registers: input function assignment for two terminals
  localparam logic [15:0] IDX_ASSIGN_A = 16'h60be;
  localparam logic [15:0] IDX_ASSIGN_B = 16'h60bf;
  localparam int ADDR_W = 18;
  localparam logic [15:0] CONTROL_MASK = 16'h3f37;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [31:0] CAPTURE_RST = 32'h00000000;
  localparam logic [7:0] FUNC_RST = 8'h00;
  localparam int CH2_OFS = 8;
  localparam int BIT_EN = 0;
  localparam int BIT_MODE = 1;
  localparam int BIT_SRC = 2;
  localparam int BIT_RISE = 4;
  localparam int BIT_FALL = 5;
  localparam int ST_EN = 0;
  localparam int ST_RISE = 1;
  localparam int ST_FALL = 2;
  localparam logic [7:0] FUNC_CH1_HIGH = 8'h0b;
  localparam logic [7:0] FUNC_CH2_HIGH = 8'h0c;
  localparam logic [7:0] FUNC_CH1_LOW = 8'h6f;
  localparam logic [7:0] FUNC_CH2_LOW = 8'h70;

  typedef struct packed {
    logic en;
    logic continuous;
    logic src_ref;
    logic rise_en;
    logic fall_en;
  } chan_cfg_type;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_type;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  function automatic chan_cfg_type cfg_of(input logic [15:0] ctl, input int ofs);
    cfg_of.en = ctl[ofs + BIT_EN];
    cfg_of.continuous = ctl[ofs + BIT_MODE];
    cfg_of.src_ref = ctl[ofs + BIT_SRC];
    cfg_of.rise_en = ctl[ofs + BIT_RISE];
    cfg_of.fall_en = ctl[ofs + BIT_FALL];
  endfunction
endpackage

/* logic/probe_sync_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module probe_sync_edge
  import probe_latch_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous level in, edges out
  input wire logic async_in,
  output probe_latch_pkg::edge_type edges
);
  logic meta_r, sync_r, last_r;
  logic meta_nxt, sync_nxt, last_nxt;
  logic [2:0] arm_r, arm_nxt;

  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
    last_nxt = sync_r;
    // no edges until last_r holds a real pin sample: a pin idling high gives no false rise
    arm_nxt = {arm_r[1:0], 1'b1};
    edges.rise = arm_r[2] & sync_r & ~last_r;
    edges.fall = arm_r[2] & ~sync_r & last_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      arm_r <= 3'b000;
    end
    else
    begin
      arm_r <= arm_nxt;
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end
endmodule
`default_nettype wire

/* logic/probe_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module probe_channel
  import probe_latch_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration and triggers
  input wire probe_latch_pkg::chan_cfg_type cfg,
  input wire probe_latch_pkg::edge_type din_edge,
  input wire probe_latch_pkg::edge_type ref_edge,
  input wire logic signed [31:0] position,
  // results
  output logic rise_done,
  output logic fall_done,
  output logic signed [31:0] rise_pos,
  output logic signed [31:0] fall_pos
);
  logic rise_done_r, fall_done_r, rise_done_nxt, fall_done_nxt;
  logic signed [31:0] rise_pos_r, fall_pos_r, rise_pos_nxt, fall_pos_nxt;
  edge_type trig;
  logic take_rise, take_fall;

  always_comb
  begin
    trig = cfg.src_ref ? ref_edge : din_edge;
    // single-shot: only while that edge has not yet latched
    take_rise = cfg.en & cfg.rise_en & trig.rise
      & (cfg.continuous | ~rise_done_r);
    take_fall = cfg.en & cfg.fall_en & trig.fall
      & (cfg.continuous | ~fall_done_r);
    rise_pos_nxt = take_rise ? position : rise_pos_r;
    fall_pos_nxt = take_fall ? position : fall_pos_r;
    rise_done_nxt = cfg.en & (rise_done_r | take_rise);
    fall_done_nxt = cfg.en & (fall_done_r | take_fall);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_done_r <= 1'b0;
      fall_done_r <= 1'b0;
      rise_pos_r <= CAPTURE_RST;
      fall_pos_r <= CAPTURE_RST;
    end
    else
    begin
      rise_done_r <= rise_done_nxt;
      fall_done_r <= fall_done_nxt;
      rise_pos_r <= rise_pos_nxt;
      fall_pos_r <= fall_pos_nxt;
    end
  end

  assign rise_done = rise_done_r;
  assign fall_done = fall_done_r;
  assign rise_pos = rise_pos_r;
  assign fall_pos = fall_pos_r;

  property p_single_shot_holds;
    @(posedge pclk) disable iff (!presetn)
    (cfg.en && !cfg.continuous && rise_done_r && $past(cfg.en) && $past(rise_done_r)
      && $past(!cfg.continuous))
    |-> $stable(rise_pos_r);
  endproperty
  a_single_shot_holds: assert property (p_single_shot_holds)
    else $error("single-shot rise capture overwritten");

  property p_rise_capture;
    @(posedge pclk) disable iff (!presetn)
    take_rise |=> (rise_pos_r == $past(position)) && rise_done_r;
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("rise capture did not latch position");

  property p_fall_capture;
    @(posedge pclk) disable iff (!presetn)
    (cfg.en && cfg.fall_en && trig.fall && !fall_done_r)
      |=> (fall_pos_r == $past(position)) && fall_done_r;
  endproperty
  a_fall_capture: assert property (p_fall_capture)
    else $error("fall capture did not latch position");

  property p_no_rise_when_off;
    @(posedge pclk) disable iff (!presetn)
    !(cfg.en && cfg.rise_en) |=> $stable(rise_pos_r);
  endproperty
  a_no_rise_when_off: assert property (p_no_rise_when_off)
    else $error("rise capture without enable");

  property p_disable_clears;
    @(posedge pclk) disable iff (!presetn)
    !cfg.en |=> !rise_done_r && !fall_done_r;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("done flags survive disable");
endmodule
`default_nettype wire

/* bench/probe_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module probe_far_side
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the bench
  input wire logic [1:0] din_req,
  input wire logic ref_req,
  input wire logic abs_req,
  input wire logic spin_req,
  // pins toward the drive
  output logic din_a,
  output logic din_b,
  output logic ref_pulse,
  output logic abs_mode,
  output logic [19:0] turn_pos
);
  // pins follow a request one edge later, as a sensor behind a cable would
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {din_b, din_a} <= 2'b10;
      ref_pulse <= 1'b0;
      abs_mode <= 1'b0;
      turn_pos <= 20'h80000;
    end
    else
    begin
      {din_b, din_a} <= din_req;
      ref_pulse <= ref_req;
      abs_mode <= abs_req;
      // sixteen steps a turn, so zero is passed once per turn
      if (spin_req)
        turn_pos <= turn_pos + 20'h10000;
    end
  end
endmodule
`default_nettype wire

/* bench/dual_probe_position_latch_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_probe_position_latch_bench;
  import probe_latch_pkg::*;
  typedef struct packed {logic w; logic err; logic [31:0] d;} note_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] pstrb;
  logic [1:0] din_req;
  logic ref_req, abs_req, spin_req, din_a, din_b, ref_pulse, abs_mode;
  logic [19:0] turn_pos;
  logic signed [31:0] cmd_position;
  logic [31:0] p [0:3];
  note_type notes[$];
  note_type n;
  int fails, total_checks;

  dual_probe_position_latch #(.POS_W(32), .TURN_W(20)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_input_terminal_a(din_a), .digital_input_terminal_b(din_b),
    .enc_ref_pulse(ref_pulse), .enc_absolute(abs_mode),
    .enc_turn_pos(turn_pos), .cmd_position(cmd_position)
  );

  probe_far_side far_side (
    .pclk(pclk), .presetn(presetn), .din_req(din_req), .ref_req(ref_req),
    .abs_req(abs_req), .spin_req(spin_req), .din_a(din_a), .din_b(din_b),
    .ref_pulse(ref_pulse), .abs_mode(abs_mode), .turn_pos(turn_pos)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one transfer; for a read d is the value expected back
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     input logic err);
    notes.push_back({w, err, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // new position held steady around one pin change
  task automatic trig(input int k, input logic lvl, output logic [31:0] at);
    rnd = xs(rnd);
    at = rnd;
    cmd_position <= rnd;
    repeat (2) @(posedge pclk);
    if (k == 2)
      ref_req <= lvl;
    else
      din_req[k] <= lvl;
    repeat (10) @(posedge pclk);
  endtask

  always @(posedge pclk)
  begin
    if (pready === 1'b1)
    begin
      n = notes.pop_front();
      check({31'h0, pslverr}, {31'h0, n.err});
      if (!n.w)
        check(prdata, n.d);
    end
  end

  initial
  begin
    #50us;
    fails++;
    $display("MISMATCH t=%0t run did not finish", $time);
    test_done;
  end

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    din_req = 2'b10;
    ref_req = 1'b0;
    abs_req = 1'b0;
    spin_req = 1'b0;
    cmd_position = '0;
    rnd = 32'd5052;
    fails = 0;
    total_checks = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++)
      apb(1'b0, IDX_CONTROL + 16'(i), 32'h0, 1'b0);
    apb(1'b1, 16'h60c0, 32'h0, 1'b1);
    apb(1'b1, IDX_CONTROL, 32'hffffffff, 1'b0);
    apb(1'b0, IDX_CONTROL, 32'h3f37, 1'b0);
    apb(1'b0, IDX_STATE, 32'h0101, 1'b0);
    apb(1'b1, IDX_C1_RISE, 32'h5a5a1234, 1'b0);
    apb(1'b0, IDX_C1_RISE, 32'h0, 1'b0);
    apb(1'b1, IDX_CONTROL, 32'h0013, 1'b0);
    apb(1'b0, IDX_CONTROL, 32'h0013, 1'b0);
    apb(1'b1, IDX_CONTROL, 32'h0, 1'b0);
    $display("test registers done");
    apb(1'b1, IDX_ASSIGN_A, 32'h0b, 1'b0);
    apb(1'b1, IDX_ASSIGN_B, 32'h70, 1'b0);
    apb(1'b0, IDX_ASSIGN_A, 32'h0b, 1'b0);
    apb(1'b1, IDX_CONTROL, 32'h0011, 1'b0);
    for (int i = 0; i < 4; i++)
      trig(0, ~i[0], p[i]);
    apb(1'b0, IDX_STATE, 32'h0003, 1'b0);
    apb(1'b0, IDX_C1_RISE, p[0], 1'b0);
    apb(1'b0, IDX_C1_FALL, 32'h0, 1'b0);
    $display("test single shot done");
    apb(1'b1, IDX_CONTROL, 32'h0, 1'b0);
    apb(1'b0, IDX_STATE, 32'h0, 1'b0);
    apb(1'b1, IDX_CONTROL, 32'h0033, 1'b0);
    for (int i = 0; i < 4; i++)
      trig(0, ~i[0], p[i]);
    apb(1'b0, IDX_STATE, 32'h0007, 1'b0);
    apb(1'b0, IDX_C1_RISE, p[2], 1'b0);
    apb(1'b0, IDX_C1_FALL, p[3], 1'b0);
    $display("test continuous done");
    apb(1'b1, IDX_CONTROL, 32'h3500, 1'b0);
    for (int i = 0; i < 4; i++)
      trig(2, ~i[0], p[i]);
    apb(1'b0, IDX_STATE, 32'h0700, 1'b0);
    apb(1'b0, IDX_C2_RISE, p[0], 1'b0);
    apb(1'b0, IDX_C2_FALL, p[1], 1'b0);
    $display("test reference pulse done");
    apb(1'b1, IDX_CONTROL, 32'h0, 1'b0);
    apb(1'b1, IDX_CONTROL, 32'h1100, 1'b0);
    trig(1, 1'b0, p[0]);
    trig(1, 1'b1, p[1]);
    apb(1'b0, IDX_STATE, 32'h0300, 1'b0);
    apb(1'b0, IDX_C2_RISE, p[0], 1'b0);
    $display("test inverted terminal done");
    apb(1'b1, IDX_CONTROL, 32'h0, 1'b0);
    rnd = xs(rnd);
    cmd_position <= rnd;
    abs_req <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, IDX_CONTROL, 32'h0015, 1'b0);
    spin_req <= 1'b1;
    repeat (12) @(posedge pclk);
    spin_req <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, IDX_STATE, 32'h0003, 1'b0);
    apb(1'b0, IDX_C1_RISE, rnd, 1'b0);
    $display("test absolute wrap done");
    test_done;
  end
endmodule
`default_nettype wire
